/* File: rtl/bopt_regs.sv */
// Bus-options quadlet register with APB access and remote view
//
// Function
// - Quadlet at 20h, mirrored to remote nodes
// - Bits 31-27 are five writable capability flags
// - Bit 27 set advertises power management
// - Bits 26-24 reserved, read zero
// - Bits 23-16 writable clock accuracy
// - Bits 15-12 request code, limit 2^(code+1)
// - Hard reset loads 2048 code, soft keeps
// - Oversize block write may get type error
// - Bits 11-8 reserved, read zero
// - Bits 7-6 writable generation counter, auto increment
// - Bits 2-0 read 010, bits 5-3 zero
`timescale 1ns/100ps

`include "bopt_defines.svh"

module bopt_regs (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Link-side events
   input  wire logic        rom_changed,
   input  wire logic        bus_reset,
   // Received block write request
   input  wire logic        wr_req_valid,
   input  wire logic [15:0] wr_req_len,
   // Remote view and link control
   output logic [31:0]      bus_info_quadlet,
   output logic             link_activation,
   output logic             power_mgmt_capable,
   output logic             ack_type_error,
   output logic             ack_len_ok
);

   // ----------------------------------------------------------------
   // State and decode
   // ----------------------------------------------------------------
   bopt_pkg::bopt_state_t st;        // Registered state
   bopt_pkg::bopt_state_t next_st;   // Next state
   logic                  setup;     // APB setup cycle
   logic                  wr_done;   // Write completes this edge
   logic                  hit_quad;  // Address is the quadlet
   logic                  hit_ctrl;  // Address is control
   logic                  hit_stat;  // Address is status
   logic                  soft_rst;  // Software reset request
   logic [31:0]           quad_now;  // Quadlet from current fields

   // Phase and address decode
   assign setup    = psel & ~penable;
   assign wr_done  = psel & penable & st.pready & pwrite;
   assign hit_quad = (paddr == `BOPT_QUAD_OFS);
   assign hit_ctrl = (paddr == `BOPT_CTRL_OFS);
   assign hit_stat = (paddr == `BOPT_STAT_OFS);
   assign soft_rst = wr_done & hit_ctrl & pwdata[`BOPT_CTRL_SRST];

   // Quadlet with reserved zeros and fixed speed code
   assign quad_now = bopt_pkg::bopt_compose(st.flags, st.accuracy,
                                            st.max_rec, st.gen);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;

      // Zero-wait APB: ready in the access phase after each setup
      next_st.pready = setup;

      // Read data and error are prepared in the setup cycle
      if (setup) begin
         next_st.pslverr = ~(hit_quad | hit_ctrl | hit_stat);
         if (pwrite) begin
            // Write: read data stays zero
            next_st.prdata = 32'h0000_0000;
         end else if (hit_quad) begin
            // Quadlet as stored
            next_st.prdata = quad_now;
         end else if (hit_ctrl) begin
            // Control: link activation, reset bit reads zero
            next_st.prdata = 32'h0000_0000;
            next_st.prdata[`BOPT_CTRL_LACT] = st.link_act;
         end else if (hit_stat) begin
            // Status: pending ROM change and current byte limit
            next_st.prdata = 32'h0000_0000;
            next_st.prdata[`BOPT_STAT_PEND] = st.rom_pend;
            next_st.prdata[`BOPT_STAT_LIM_MSB:`BOPT_STAT_LIM_LSB] =
               bopt_pkg::bopt_limit(st.max_rec);
         end else begin
            // Unmapped: zero data, error flagged
            next_st.prdata = 32'h0000_0000;
         end
      end else if (~psel) begin
         // Idle bus: clear the error flag, read data holds
         next_st.pslverr = 1'b0;
      end

      // Generation counter steps at bus reset after a ROM change
      if (bus_reset & st.rom_pend) begin
         next_st.gen = st.gen + 2'h1;
      end

      // Pending flag: a new change wins over the clear
      next_st.rom_pend = rom_changed | (st.rom_pend & ~bus_reset);

      // Software reset clears host fields but keeps request code
      if (soft_rst) begin
         next_st.flags    = `BOPT_FLAGS_RST;
         next_st.accuracy = `BOPT_ACC_RST;
         next_st.gen      = `BOPT_GEN_RST;
         next_st.link_act = 1'b0;
      end else if (wr_done & hit_ctrl) begin
         // Link activation level
         next_st.link_act = pwdata[`BOPT_CTRL_LACT];
      end

      // Host write to the quadlet touches writable fields only
      if (wr_done & hit_quad) begin
         next_st.flags    = pwdata[`BOPT_FLAGS_MSB:`BOPT_FLAGS_LSB];
         next_st.accuracy = pwdata[`BOPT_ACC_MSB:`BOPT_ACC_LSB];
         next_st.max_rec  = pwdata[`BOPT_MREC_MSB:`BOPT_MREC_LSB];
         next_st.gen      = pwdata[`BOPT_GEN_MSB:`BOPT_GEN_LSB];
         // Reserved and speed bits of pwdata are dropped here
      end

      // Remote view refreshed every cycle from the stored fields
      next_st.quad = bopt_pkg::bopt_compose(next_st.flags, next_st.accuracy,
                                            next_st.max_rec, next_st.gen);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Hard reset: request code at its 2048-byte value
         st          <= '0;
         st.max_rec  <= `BOPT_MREC_RST;
         st.quad     <= {16'h0000, `BOPT_MREC_RST, 9'h000, `BOPT_SPD_CODE};
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Length check of received block writes
   // ----------------------------------------------------------------
   bopt_len_chk u_len_chk (
      .pclk           (pclk),
      .presetn        (presetn),
      .max_rec        (st.max_rec),
      .wr_req_valid   (wr_req_valid),
      .wr_req_len     (wr_req_len),
      .ack_type_error (ack_type_error),
      .ack_len_ok     (ack_len_ok)
   );

   // ----------------------------------------------------------------
   // Outputs, all from flip-flops
   // ----------------------------------------------------------------
   assign prdata             = st.prdata;
   assign pready             = st.pready;
   assign pslverr            = st.pslverr;
   assign bus_info_quadlet   = st.quad;
   // Host must have fields valid before raising this
   assign link_activation    = st.link_act;
   // Capability advertised from the bit-27 flag
   assign power_mgmt_capable = st.quad[`BOPT_FLAGS_LSB];

endmodule : bopt_regs

/* File: shared/bopt_defines.svh */
// Offsets, field positions, reset values and codes of the bus-options block
`ifndef BOPT_DEFINES_SVH
`define BOPT_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define BOPT_CTRL_OFS      8'h00
`define BOPT_STAT_OFS      8'h04
`define BOPT_QUAD_OFS      8'h20

// ----------------------------------------------------------------
// Bus-options quadlet fields
// ----------------------------------------------------------------
`define BOPT_FLAGS_MSB     31
`define BOPT_FLAGS_LSB     27
`define BOPT_ACC_MSB       23
`define BOPT_ACC_LSB       16
`define BOPT_MREC_MSB      15
`define BOPT_MREC_LSB      12
`define BOPT_GEN_MSB       7
`define BOPT_GEN_LSB       6
`define BOPT_SPD_MSB       2
`define BOPT_SPD_LSB       0

// ----------------------------------------------------------------
// Fixed and reset values
// ----------------------------------------------------------------
`define BOPT_MREC_RST      4'hA
`define BOPT_SPD_CODE      3'h2
`define BOPT_ACC_RST       8'h00
`define BOPT_FLAGS_RST     5'h00
`define BOPT_GEN_RST       2'h0

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define BOPT_CTRL_SRST     0
`define BOPT_CTRL_LACT     1
`define BOPT_STAT_PEND     0
`define BOPT_STAT_LIM_LSB  8
`define BOPT_STAT_LIM_MSB  24

`endif

/* File: shared/bopt_pkg.sv */
// Types and shared helpers of the bus-options block
package bopt_pkg;

   // ----------------------------------------------------------------
   // Register block state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0]  flags;      // Capability flags, bit 4 = top flag
      logic [7:0]  accuracy;   // Cycle-master clock accuracy
      logic [3:0]  max_rec;    // Maximum request code
      logic [1:0]  gen;        // Generation counter
      logic        link_act;   // Link activation level
      logic        rom_pend;   // Configuration ROM changed since reset
      logic        pready;     // APB ready
      logic        pslverr;    // APB error
      logic [31:0] prdata;     // APB read data
      logic [31:0] quad;       // Quadlet as seen by remote nodes
   } bopt_state_t;

   // ----------------------------------------------------------------
   // Length checker state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic ack_err;           // Oversize block write seen
      logic ack_ok;            // Block write within limit
   } bopt_chk_t;

   // Byte limit of a request code: 2^(code+1)
   function automatic logic [16:0] bopt_limit(input logic [3:0] code);
      bopt_limit = 17'h0_0001 << (code + 5'h01);
   endfunction : bopt_limit

   // Assemble the quadlet; reserved bits are zero, speed is fixed
   function automatic logic [31:0] bopt_compose(input logic [4:0] flags,
                                                input logic [7:0] acc,
                                                input logic [3:0] mrec,
                                                input logic [1:0] gen);
      bopt_compose = {flags, 3'h0, acc, mrec, 4'h0, gen, 3'h0, 3'h2};
   endfunction : bopt_compose

endpackage : bopt_pkg

/* File: rtl/bopt_len_chk.sv */
// Block write length check against the maximum request code
`timescale 1ns/100ps

`include "bopt_defines.svh"

module bopt_len_chk (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Current maximum request code
   input  wire logic [3:0]  max_rec,
   // Received block write request
   input  wire logic        wr_req_valid,
   input  wire logic [15:0] wr_req_len,
   // Verdict pulses
   output logic             ack_type_error,
   output logic             ack_len_ok
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   bopt_pkg::bopt_chk_t st;        // Registered verdict
   bopt_pkg::bopt_chk_t next_st;   // Next verdict
   logic [16:0]         limit;     // Byte limit of current code

   // Limit follows the code as the host leaves it
   assign limit = bopt_pkg::bopt_limit(max_rec);

   // Compare each request once, one-cycle verdict pulse
   always_comb begin
      next_st = '0;
      if (wr_req_valid) begin
         // Longer than limit earns a type error
         if ({1'b0, wr_req_len} > limit) begin
            next_st.ack_err = 1'b1;
         end else begin
            next_st.ack_ok = 1'b1;
         end
      end
   end

   // Verdict register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign ack_type_error = st.ack_err;
   assign ack_len_ok     = st.ack_ok;

endmodule : bopt_len_chk

/* File: bench/bopt_chk.sv */
// Port checker of the bus-options register block
`timescale 1ns/100ps

module bopt_chk (
   // Clock, reset and APB
   input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata, prdata,
   // Link side and remote view
   input wire logic        rom_changed, bus_reset, wr_req_valid,
   input wire logic [15:0] wr_req_len,
   input wire logic [31:0] bus_info_quadlet,
   input wire logic        link_activation, power_mgmt_capable, ack_type_error, ack_len_ok
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access edges of a quadlet write and a software reset
   wire quad_wr = psel && penable && pready && pwrite && paddr == 8'h20;
   wire srst_wr = psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[0];
   // Request longer than the current byte limit
   wire too_long = {1'b0, wr_req_len} > (17'h0_0001 << (bus_info_quadlet[15:12] + 5'h01));

   fixed_bits_a: assert property (bus_info_quadlet[26:24] == 3'h0 &&
      bus_info_quadlet[11:8] == 4'h0 && bus_info_quadlet[5:0] == 6'h02)
      else $error("fixed quadlet bits wrong");
   read_mirror_a: assert property (psel && !penable && !pwrite && paddr == 8'h20
      |=> pready && !pslverr && prdata == bus_info_quadlet) else $error("read differs");
   flags_wr_a: assert property (quad_wr |=> bus_info_quadlet[31:27] == $past(pwdata[31:27])
      && power_mgmt_capable == $past(pwdata[27])) else $error("flags not written");
   fields_wr_a: assert property (quad_wr |=> bus_info_quadlet[23:12] == $past(pwdata[23:12])
      && bus_info_quadlet[7:6] == $past(pwdata[7:6])) else $error("fields not written");
   gen_step_a: assert property (rom_changed ##1 (!bus_reset && !psel)[*2] ##1 (bus_reset && !psel)
      |=> bus_info_quadlet[7:6] == $past(bus_info_quadlet[7:6]) + 2'h1)
      else $error("generation not stepped");
   len_err_a: assert property (wr_req_valid && too_long |=> ack_type_error && !ack_len_ok)
      else $error("oversize request not flagged");
   len_ok_a: assert property (wr_req_valid && !too_long |=> ack_len_ok && !ack_type_error)
      else $error("request within limit flagged");
   hard_rst_a: assert property ($rose(presetn) |-> bus_info_quadlet[15:12] == 4'hA)
      else $error("request code not loaded");
   soft_keep_a: assert property (srst_wr |=> !link_activation &&
      bus_info_quadlet[15:12] == $past(bus_info_quadlet[15:12])) else $error("code lost");

   // Main scenarios
   quad_wr_c: cover property (quad_wr);
   len_err_c: cover property (ack_type_error);
   srst_c: cover property (srst_wr);
endmodule : bopt_chk

bind bopt_regs bopt_chk u_bopt_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
   .pslverr, .paddr, .pwdata, .prdata, .rom_changed, .bus_reset, .wr_req_valid, .wr_req_len,
   .bus_info_quadlet, .link_activation, .power_mgmt_capable, .ack_type_error, .ack_len_ok);

/* File: bench/bopt_link_model.sv */
// Link-side model: ROM changes, bus resets and received block writes
`timescale 1ns/100ps

module bopt_link_model (
   // Clock
   input wire logic  pclk,
   // Events towards the block
   output logic        rom_changed,
   output logic        bus_reset,
   output logic        wr_req_valid,
   output logic [15:0] wr_req_len
);
   initial begin
      rom_changed = 1'b0;
      bus_reset = 1'b0;
      wr_req_valid = 1'b0;
      wr_req_len = 16'h0000;
   end

   // ROM change, two quiet cycles, then a bus reset
   task automatic rom_update();
      @(posedge pclk) rom_changed <= 1'b1;
      @(posedge pclk) rom_changed <= 1'b0;
      repeat (2) @(posedge pclk);
      bus_reset <= 1'b1;
      @(posedge pclk) bus_reset <= 1'b0;
   endtask : rom_update

   // Lone bus reset with no ROM change before it
   task automatic reset_pulse();
      @(posedge pclk) bus_reset <= 1'b1;
      @(posedge pclk) bus_reset <= 1'b0;
   endtask : reset_pulse

   // One block write; length lines scrambled outside the pulse
   task automatic block_write(input logic [15:0] len);
      @(posedge pclk);
      wr_req_valid <= 1'b1;
      wr_req_len <= len;
      @(posedge pclk);
      wr_req_valid <= 1'b0;
      wr_req_len <= ~len;
   endtask : block_write
endmodule : bopt_link_model

/* File: bench/tb_bopt_regs.sv */
// Testbench of the bus-options register block
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
   $display("FAIL %s exp %h got %h", n, e, g); end end

module tb_bopt_regs;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, bus_info_quadlet, rd_data;
   logic        pready, pslverr, rd_err, rom_changed, bus_reset, wr_req_valid;
   logic        link_activation, power_mgmt_capable, ack_type_error, ack_len_ok;
   logic [15:0] wr_req_len;
   int          err_count = 0, comparisons = 0, cycles = 0;

   always #50 pclk = ~pclk;

   bopt_regs u_bopt_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .rom_changed, .bus_reset, .wr_req_valid, .wr_req_len,
      .bus_info_quadlet, .link_activation, .power_mgmt_capable, .ack_type_error, .ack_len_ok);
   bopt_link_model u_bopt_link_model (.pclk, .rom_changed, .bus_reset, .wr_req_valid,
      .wr_req_len);

   // One APB transfer: setup, then access until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic t_fields();
      apb(1'b0, 8'h20, 32'h0000_0000);
      `CHK("reset quad", 32'h0000_A002, rd_data)
      apb(1'b1, 8'h20, 32'hFFFF_BFFF);
      apb(1'b0, 8'h20, 32'h0000_0000);
      `CHK("full quad", 32'hF8FF_B0C2, rd_data)
      `CHK("remote quad", 32'hF8FF_B0C2, bus_info_quadlet)
      `CHK("pm flag", 1'b1, power_mgmt_capable)
      apb(1'b1, 8'h20, 32'h0700_8F3F);
      apb(1'b0, 8'h20, 32'h0000_0000);
      `CHK("low quad", 32'h0000_8002, rd_data)
      `CHK("pm clear", 1'b0, power_mgmt_capable)
      $display("t_fields done");
   endtask : t_fields

   task automatic t_gen();
      u_bopt_link_model.rom_update();
      apb(1'b0, 8'h20, 32'h0000_0000);
      `CHK("gen step", 32'h0000_8042, rd_data)
      u_bopt_link_model.reset_pulse();
      apb(1'b0, 8'h20, 32'h0000_0000);
      `CHK("gen hold", 32'h0000_8042, rd_data)
      apb(1'b1, 8'h20, 32'h0000_80C0);
      u_bopt_link_model.rom_update();
      apb(1'b0, 8'h20, 32'h0000_0000);
      `CHK("gen wrap", 32'h0000_8002, rd_data)
      $display("t_gen done");
   endtask : t_gen

   task automatic t_len();
      logic [3:0]  code [4] = '{4'h8, 4'h8, 4'hA, 4'hA};
      logic [15:0] len [4] = '{16'h0200, 16'h0201, 16'h0800, 16'h0801};
      logic [31:0] lim [4] = '{32'h0002_0000, 32'h0002_0000, 32'h0008_0000, 32'h0008_0000};
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 8'h20, {16'h0000, code[i], 12'h000});
         apb(1'b0, 8'h04, 32'h0000_0000);
         `CHK("status limit", lim[i], rd_data)
         u_bopt_link_model.block_write(len[i]);
         #1;
         `CHK("type error", i[0], ack_type_error)
         `CHK("length ok", !i[0], ack_len_ok)
      end
      $display("t_len done");
   endtask : t_len

   task automatic t_soft();
      apb(1'b1, 8'h20, 32'h8000_9000);
      apb(1'b1, 8'h00, 32'h0000_0002);
      #1;
      `CHK("link on", 1'b1, link_activation)
      apb(1'b1, 8'h00, 32'h0000_0001);
      apb(1'b0, 8'h20, 32'h0000_0000);
      `CHK("soft quad", 32'h0000_9002, rd_data)
      `CHK("link off", 1'b0, link_activation)
      apb(1'b1, 8'h40, 32'hFFFF_FFFF);
      `CHK("unmapped err", 1'b1, rd_err)
      apb(1'b0, 8'h20, 32'h0000_0000);
      `CHK("quad kept", 32'h0000_9002, rd_data)
      $display("t_soft done");
   endtask : t_soft

   task automatic t_hard();
      @(posedge pclk) presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h20, 32'h0000_0000);
      `CHK("hard quad", 32'h0000_A002, rd_data)
      $display("t_hard done");
   endtask : t_hard

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   // Hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         stop_test();
      end
   end

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_fields();
      t_gen();
      t_len();
      t_soft();
      t_hard();
      stop_test();
   end
endmodule : tb_bopt_regs
